// ==== logic/csr_pkg.sv ====
`default_nettype none

package csr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and serial timing
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_BPS = 1200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int FRAME_BITS = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Record content
  localparam int VAL_CHARS = 6;
  localparam int MEAS_TIME_S = 1;
  localparam int VALUE_COUNT = 2;
  // Arbitrary model character, stands in for the real sensor type code
  localparam logic [7:0] SENSOR_TYPE_CH = 8'h6b;
  localparam logic [7:0] CHK_BIAS = 8'h20;
  localparam logic [15:0] SUM_RESET = 16'h0000;

  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_WILD = 8'h3f;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_R = 8'h52;

  localparam logic [7:0] TIME_D2 = CH_0 + 8'(MEAS_TIME_S / 100);
  localparam logic [7:0] TIME_D1 = CH_0 + 8'((MEAS_TIME_S / 10) % 10);
  localparam logic [7:0] TIME_D0 = CH_0 + 8'(MEAS_TIME_S % 10);
  localparam logic [7:0] COUNT_D1 = CH_0 + 8'(VALUE_COUNT / 10);
  localparam logic [7:0] COUNT_D0 = CH_0 + 8'(VALUE_COUNT % 10);

  ////////////////////////////////////////////////////////////////////////////
  // States, reply kinds and reply segments
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_MEAS = 2'b01,
    ST_SEND = 2'b11,
    ST_IDLE = 2'b10
  } csr_state_t;

  typedef enum logic [2:0] {
    K_NONE, K_PWRUP, K_MREPLY, K_CREPLY, K_SREQ, K_DATA, K_TABREC
  } csr_kind_t;

  typedef enum logic [4:0] {
    SG_ADDR, SG_TAB, SG_SP, SG_CR, SG_LF, SG_TYPE, SG_CHK, SG_PSC, SG_PST,
    SG_MSC, SG_MST, SG_COND, SG_TEMP, SG_TIME, SG_N1, SG_N2, SG_END
  } csr_seg_t;

  localparam int SEQ_LEN = 10;
  localparam logic [3:0] SEQ_LAST = 4'h9;
  typedef csr_seg_t csr_seq_t [SEQ_LEN];

  localparam csr_seq_t SQ_PWRUP = '{SG_TAB, SG_MSC, SG_COND, SG_SP, SG_MST, SG_TEMP, SG_CR,
                                   SG_TYPE, SG_CHK, SG_END};
  localparam csr_seq_t SQ_TABREC = '{SG_ADDR, SG_TAB, SG_MSC, SG_COND, SG_SP, SG_MST,
                                    SG_TEMP, SG_CR, SG_TYPE, SG_CHK};
  localparam csr_seq_t SQ_MREPLY = '{SG_ADDR, SG_TIME, SG_N1, SG_CR, SG_LF, SG_END, SG_END,
                                    SG_END, SG_END, SG_END};
  localparam csr_seq_t SQ_CREPLY = '{SG_ADDR, SG_TIME, SG_N2, SG_CR, SG_LF, SG_END, SG_END,
                                    SG_END, SG_END, SG_END};
  localparam csr_seq_t SQ_SREQ = '{SG_ADDR, SG_CR, SG_LF, SG_END, SG_END, SG_END, SG_END,
                                  SG_END, SG_END, SG_END};
  localparam csr_seq_t SQ_DATA = '{SG_ADDR, SG_PSC, SG_COND, SG_PST, SG_TEMP, SG_CR, SG_LF,
                                  SG_END, SG_END, SG_END};

  function automatic csr_seg_t csr_seg(input csr_kind_t k, input logic [3:0] s);
    csr_seg_t g;
    g = SG_END;
    if (s <= SEQ_LAST) begin
      case (k)
        K_PWRUP: g = SQ_PWRUP[s];
        K_TABREC: g = SQ_TABREC[s];
        K_MREPLY: g = SQ_MREPLY[s];
        K_CREPLY: g = SQ_CREPLY[s];
        K_SREQ: g = SQ_SREQ[s];
        K_DATA: g = SQ_DATA[s];
        default: g = SG_END;
      endcase
    end
    return g;
  endfunction

endpackage : csr_pkg

`default_nettype wire

// ==== logic/csr_serial_phy.sv ====
`default_nettype none

// One UART frame engine for both line formats; receive is command format only
module csr_serial_phy #(
  parameter int BIT_CYCLES = csr_pkg::BIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_pwrup,
  output logic tx_ready,
  output logic tx_busy,
  output logic tx_line,
  input wire logic rx_en,
  input wire logic line_in,
  output logic rx_valid,
  output logic [6:0] rx_char
);

  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL_BIT = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2);
  localparam logic [3:0] LAST_IDX = 4'(csr_pkg::FRAME_BITS - 1);

  typedef struct packed {
    logic tx_busy;
    logic tx_inv;
    logic [CW-1:0] tx_cnt;
    logic [3:0] tx_left;
    logic [9:0] tx_sh;
    logic tx_line;
    logic rx_busy;
    logic rx_prev;
    logic [CW-1:0] rx_cnt;
    logic [3:0] rx_left;
    logic [8:0] rx_sh;
    logic rx_valid;
    logic [6:0] rx_char;
  } csr_phy_t;

  csr_phy_t r, n;
  logic [9:0] frame;
  logic rx_bit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.rx_valid = 1'b0;
    n.rx_prev = line_in;
    // Command format carries 7 bits plus even parity, power-up format 8 bits
    if (tx_pwrup) begin
      frame = {1'b1, tx_byte, 1'b0};
    end else begin
      frame = {1'b1, ^tx_byte[6:0], tx_byte[6:0], 1'b0};
    end
    // Command format is inverted: logical zero is the high level
    rx_bit = ~line_in;

    if (!r.tx_busy) begin
      if (tx_valid) begin
        n.tx_busy = 1'b1;
        n.tx_inv = ~tx_pwrup;
        n.tx_line = frame[0] ^ ~tx_pwrup;
        n.tx_sh = frame >> 1;
        n.tx_left = LAST_IDX;
        n.tx_cnt = FULL_BIT;
      end
    end else if (r.tx_cnt != '0) begin
      n.tx_cnt = r.tx_cnt - 1'b1;
    end else if (r.tx_left == 4'h0) begin
      n.tx_busy = 1'b0;
    end else begin
      n.tx_line = r.tx_sh[0] ^ r.tx_inv;
      n.tx_sh = r.tx_sh >> 1;
      n.tx_left = r.tx_left - 1'b1;
      n.tx_cnt = FULL_BIT;
    end

    if (!rx_en) begin
      n.rx_busy = 1'b0;
    end else if (!r.rx_busy) begin
      if (line_in && !r.rx_prev) begin
        n.rx_busy = 1'b1;
        n.rx_cnt = HALF_BIT;
        n.rx_left = LAST_IDX;
      end
    end else if (r.rx_cnt != '0) begin
      n.rx_cnt = r.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = FULL_BIT;
      n.rx_left = r.rx_left - 1'b1;
      if (r.rx_left == LAST_IDX) begin
        // A glitch that is gone by mid start bit is not a frame
        n.rx_busy = ~rx_bit;
      end else if (r.rx_left != 4'h0) begin
        n.rx_sh = {rx_bit, r.rx_sh[8:1]};
      end else begin
        n.rx_busy = 1'b0;
        n.rx_valid = rx_bit && !(^r.rx_sh[8:1]);
        n.rx_char = r.rx_sh[7:1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.tx_line <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign tx_ready = ~r.tx_busy;
  assign tx_busy = r.tx_busy;
  assign tx_line = r.tx_line;
  assign rx_valid = r.rx_valid;
  assign rx_char = r.rx_char;

endmodule : csr_serial_phy

`default_nettype wire

// ==== logic/csr_responder.sv ====
`default_nettype none

module csr_responder #(
  parameter int BIT_CYCLES = csr_pkg::BIT_CYCLES,
  parameter int VAL_CHARS = csr_pkg::VAL_CHARS,
  parameter int LW = $clog2(VAL_CHARS + 1)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  input wire logic [7:0] stored_addr,
  output logic meas_start,
  input wire logic meas_ready,
  input wire logic cond_neg,
  input wire logic [LW-1:0] cond_len,
  input wire logic [VAL_CHARS*8-1:0] cond_text,
  input wire logic temp_neg,
  input wire logic [LW-1:0] temp_len,
  input wire logic [VAL_CHARS*8-1:0] temp_text
);

  typedef struct packed {
    csr_pkg::csr_state_t st;
    logic pwrup;
    logic [7:0] addr;
    logic meas_start;
    csr_pkg::csr_kind_t kind;
    csr_pkg::csr_kind_t pend;
    logic [3:0] step;
    logic [LW-1:0] ci;
    logic [15:0] sum;
    logic cond_neg;
    logic [LW-1:0] cond_len;
    logic [VAL_CHARS*8-1:0] cond_txt;
    logic temp_neg;
    logic [LW-1:0] temp_len;
    logic [VAL_CHARS*8-1:0] temp_txt;
    logic [7:0] h2;
    logic [7:0] h1;
    logic [7:0] h0;
    logic [2:0] cnt;
    logic line_out;
    logic line_oe;
  } csr_resp_t;

  csr_resp_t r, n;
  csr_pkg::csr_seg_t seg;
  logic [7:0] ch;
  logic [LW-1:0] clen;
  logic [7:0] chk;
  logic tx_valid;
  logic tx_ready;
  logic tx_busy;
  logic tx_line;
  logic rx_valid;
  logic [6:0] rx_char;
  logic [7:0] rx_byte;
  logic addr_hit2;
  logic addr_hit3;

  function automatic logic addr_match(input logic [7:0] c, input logic [7:0] own);
    return (c == own) || (c == csr_pkg::CH_WILD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  csr_serial_phy #(
    .BIT_CYCLES(BIT_CYCLES)
  ) csr_serial_phy_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tx_valid(tx_valid),
    .tx_byte(ch),
    .tx_pwrup(r.pwrup),
    .tx_ready(tx_ready),
    .tx_busy(tx_busy),
    .tx_line(tx_line),
    .rx_en(r.st == csr_pkg::ST_IDLE && !r.line_oe),
    .line_in(line_in),
    .rx_valid(rx_valid),
    .rx_char(rx_char)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Character source for the current reply segment
  always_comb begin
    seg = csr_pkg::csr_seg(r.kind, r.step);
    // Only the low six bits of the sum survive the modulo
    chk = {2'b00, r.sum[5:0]} + csr_pkg::CHK_BIAS;
    ch = csr_pkg::CH_SP;
    clen = LW'(1);
    case (seg)
      csr_pkg::SG_ADDR: ch = r.addr;
      csr_pkg::SG_TAB: ch = csr_pkg::CH_TAB;
      csr_pkg::SG_SP: ch = csr_pkg::CH_SP;
      csr_pkg::SG_CR: ch = csr_pkg::CH_CR;
      csr_pkg::SG_LF: ch = csr_pkg::CH_LF;
      csr_pkg::SG_TYPE: ch = csr_pkg::SENSOR_TYPE_CH;
      csr_pkg::SG_CHK: ch = chk;
      csr_pkg::SG_PSC: ch = r.cond_neg ? csr_pkg::CH_MINUS : csr_pkg::CH_PLUS;
      csr_pkg::SG_PST: ch = r.temp_neg ? csr_pkg::CH_MINUS : csr_pkg::CH_PLUS;
      csr_pkg::SG_MSC: begin
        ch = csr_pkg::CH_MINUS;
        clen = r.cond_neg ? LW'(1) : LW'(0);
      end
      csr_pkg::SG_MST: begin
        ch = csr_pkg::CH_MINUS;
        clen = r.temp_neg ? LW'(1) : LW'(0);
      end
      csr_pkg::SG_COND: begin
        ch = r.cond_txt[8*r.ci +: 8];
        clen = r.cond_len;
      end
      csr_pkg::SG_TEMP: begin
        ch = r.temp_txt[8*r.ci +: 8];
        clen = r.temp_len;
      end
      csr_pkg::SG_TIME: begin
        clen = LW'(3);
        if (r.ci == LW'(0)) begin
          ch = csr_pkg::TIME_D2;
        end else if (r.ci == LW'(1)) begin
          ch = csr_pkg::TIME_D1;
        end else begin
          ch = csr_pkg::TIME_D0;
        end
      end
      csr_pkg::SG_N1: ch = csr_pkg::COUNT_D0;
      csr_pkg::SG_N2: begin
        clen = LW'(2);
        ch = (r.ci == LW'(0)) ? csr_pkg::COUNT_D1 : csr_pkg::COUNT_D0;
      end
      csr_pkg::SG_END: clen = LW'(0);
      default: clen = LW'(0);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    n = r;
    n.meas_start = 1'b0;
    tx_valid = 1'b0;
    rx_byte = {1'b0, rx_char};
    addr_hit2 = addr_match(r.h1, r.addr);
    addr_hit3 = addr_match(r.h2, r.addr);

    case (r.st)
      csr_pkg::ST_BOOT: begin
        n.addr = stored_addr;
        if (stored_addr == csr_pkg::CH_0) begin
          n.pwrup = 1'b1;
          n.pend = csr_pkg::K_PWRUP;
          n.st = csr_pkg::ST_MEAS;
          n.meas_start = 1'b1;
        end else begin
          n.st = csr_pkg::ST_IDLE;
        end
      end

      csr_pkg::ST_MEAS: begin
        if (meas_ready) begin
          n.cond_neg = cond_neg;
          n.cond_len = cond_len;
          n.cond_txt = cond_text;
          n.temp_neg = temp_neg;
          n.temp_len = temp_len;
          n.temp_txt = temp_text;
          if (r.pend == csr_pkg::K_NONE) begin
            n.st = csr_pkg::ST_IDLE;
          end else begin
            n.kind = r.pend;
            n.st = csr_pkg::ST_SEND;
            n.step = 4'h0;
            n.ci = LW'(0);
            n.sum = csr_pkg::SUM_RESET;
          end
        end
      end

      csr_pkg::ST_SEND: begin
        if (seg == csr_pkg::SG_END) begin
          // Hold until the stop bit is out so the line is not cut mid frame
          if (!tx_busy) begin
            n.pwrup = 1'b0;
            n.st = csr_pkg::ST_IDLE;
            if (r.kind == csr_pkg::K_MREPLY || r.kind == csr_pkg::K_CREPLY) begin
              n.st = csr_pkg::ST_MEAS;
              n.meas_start = 1'b1;
              // Concurrent results wait silently for a data command
              n.pend = (r.kind == csr_pkg::K_MREPLY) ? csr_pkg::K_SREQ
                                                     : csr_pkg::K_NONE;
            end
          end
        end else if (clen == LW'(0)) begin
          n.step = r.step + 1'b1;
        end else begin
          tx_valid = 1'b1;
          if (tx_ready) begin
            if (seg != csr_pkg::SG_ADDR && seg != csr_pkg::SG_CHK) begin
              n.sum = r.sum + {8'h00, ch};
            end
            if (r.ci == clen - 1'b1) begin
              n.ci = LW'(0);
              n.step = r.step + 1'b1;
            end else begin
              n.ci = r.ci + 1'b1;
            end
          end
        end
      end

      csr_pkg::ST_IDLE: begin
        if (rx_valid) begin
          if (rx_byte == csr_pkg::CH_BANG) begin
            n.cnt = 3'h0;
            n.step = 4'h0;
            n.ci = LW'(0);
            n.sum = csr_pkg::SUM_RESET;
            if (r.cnt == 3'h2 && addr_hit2 && r.h0 == csr_pkg::CH_M) begin
              n.kind = csr_pkg::K_MREPLY;
              n.st = csr_pkg::ST_SEND;
            end else if (r.cnt == 3'h2 && addr_hit2 && r.h0 == csr_pkg::CH_C) begin
              n.kind = csr_pkg::K_CREPLY;
              n.st = csr_pkg::ST_SEND;
            end else if (r.cnt == 3'h3 && addr_hit3 && r.h0 == csr_pkg::CH_0) begin
              if (r.h1 == csr_pkg::CH_D) begin
                n.kind = csr_pkg::K_DATA;
                n.st = csr_pkg::ST_SEND;
              end else if (r.h1 == csr_pkg::CH_R) begin
                n.pend = csr_pkg::K_DATA;
                n.st = csr_pkg::ST_MEAS;
                n.meas_start = 1'b1;
              end
            end else if (r.cnt == 3'h3 && addr_hit3 && r.h0 == csr_pkg::CH_3 &&
                         r.h1 == csr_pkg::CH_R) begin
              n.pend = csr_pkg::K_TABREC;
              n.st = csr_pkg::ST_MEAS;
              n.meas_start = 1'b1;
            end
          end else begin
            n.h2 = r.h1;
            n.h1 = r.h0;
            n.h0 = rx_byte;
            // Saturate so an over-long command matches nothing
            n.cnt = (r.cnt == 3'h4) ? 3'h4 : r.cnt + 1'b1;
          end
        end
      end

      default: n.st = csr_pkg::ST_BOOT;
    endcase

    // Power-up phase owns the line: high while measuring, then the record
    n.line_oe = r.pwrup | tx_busy;
    n.line_out = (r.pwrup && r.st != csr_pkg::ST_SEND) ? 1'b1 : tx_line;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign line_out = r.line_out;
  assign line_oe = r.line_oe;
  assign meas_start = r.meas_start;

endmodule : csr_responder

`default_nettype wire

// ==== tb/csr_responder_properties.sv ====
`default_nettype none

module csr_responder_chk #(
  parameter int BIT_CYCLES = 16,
  parameter int VAL_CHARS = 6,
  parameter int LW = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe,
  input wire logic [7:0] stored_addr,
  input wire logic meas_start,
  input wire logic meas_ready,
  input wire logic cond_neg,
  input wire logic [LW-1:0] cond_len,
  input wire logic [VAL_CHARS*8-1:0] cond_text,
  input wire logic temp_neg,
  input wire logic [LW-1:0] temp_len,
  input wire logic [VAL_CHARS*8-1:0] temp_text
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_r;
  logic out_q_r;
  logic oe_q_r;
  logic boot_r;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current level; boot_r is high from reset until line_oe first falls
  always_ff @(posedge clk_sys) begin
    out_q_r <= line_out;
    oe_q_r <= line_oe;
    if (!rst_n || line_out != out_q_r) begin
      run_r <= 8'h00;
    end else if (run_r != 8'hff) begin
      run_r <= run_r + 8'h01;
    end
    if (!rst_n) begin
      boot_r <= 1'h1;
    end else if (oe_q_r && !line_oe) begin
      boot_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_RAISE: assert property ($rose(rst_n) && stored_addr == 8'h30 |-> ##[1:4] (line_oe && line_out))
    else $error("line not raised after power-up");
  AST_SUPPRESS: assert property ($rose(rst_n) && stored_addr != 8'h30 |-> !(line_oe || meas_start) [*8])
    else $error("power-up record not suppressed");
  AST_MSTART: assert property (meas_start |-> !line_oe ##1 !meas_start)
    else $error("measurement start not a quiet single pulse");
  AST_BITTIME: assert property (line_oe && $past(line_oe) && line_out != $past(line_out) |-> run_r >= BIT_CYCLES - 1)
    else $error("bit shorter than one bit time");
  AST_HOLD_HIGH: assert property ($rose(line_oe) && $past(meas_start) |-> (line_oe && line_out) [*8])
    else $error("raised line not held high");
  AST_FIRST_START: assert property (meas_ready && line_oe && line_out |-> ##[1:8] (line_oe && !line_out))
    else $error("no start bit after reading ready");
  AST_CMD_START: assert property (!boot_r && $rose(line_oe) |-> line_out)
    else $error("command reply start bit not high");
  AST_ONE_RECORD: assert property (!boot_r && meas_start |=> !line_oe [*4])
    else $error("second power-up raise");
endmodule // csr_responder_chk

`default_nettype wire

// ==== tb/csr_logger_model.sv ====
`default_nettype none

module csr_logger_model #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic line,
  output logic drv_oe,
  output logic drv_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    drv_oe = 1'h0;
    drv_out = 1'h0;
  end

  // Released after half the stop bit: the pull-down holds the stop level for us
  task automatic send_cmd(input string s);
    logic [9:0] f;
    byte c;
    for (int k = 0; k < s.len(); k++) begin
      c = s[k];
      f = {1'h1, ^c[6:0], c[6:0], 1'h0};
      repeat (BIT_CYCLES) @(negedge clk_sys);
      drv_oe = 1'h1;
      for (int i = 0; i < 10; i++) begin
        drv_out = ~f[i];
        repeat ((i == 9) ? BIT_CYCLES / 2 : BIT_CYCLES) @(negedge clk_sys);
      end
      drv_oe = 1'h0;
    end
  endtask

  // Returns the frame in logical levels, start in bit 0; all x if none came
  task automatic get_char(input bit pwrup, output logic [9:0] f);
    int n;
    n = 0;
    f = 'x;
    while (line !== pwrup && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    while (line !== !pwrup && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n < 9000) begin
      repeat (BIT_CYCLES / 2) @(negedge clk_sys);
      for (int i = 0; i < 10; i++) begin
        f[i] = pwrup ? line : !line;
        if (i < 9) repeat (BIT_CYCLES) @(negedge clk_sys);
      end
    end
  endtask
endmodule // csr_logger_model

`default_nettype wire

// ==== tb/tb.sv ====
`default_nettype none

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = 16;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] stored_addr = 8'h30;
  logic meas_ready = 1'h0;
  logic cond_neg = 1'h0;
  logic [2:0] cond_len = 3'h0;
  logic [47:0] cond_text = 48'h0000_0000_0000;
  logic temp_neg = 1'h0;
  logic [2:0] temp_len = 3'h0;
  logic [47:0] temp_text = 48'h0000_0000_0000;
  logic line_out;
  logic line_oe;
  logic meas_start;
  logic drv_oe;
  logic drv_out;
  logic line_w;
  int error_cnt = 0;
  int check_count = 0;

  always #2.5 clk_sys = ~clk_sys;
  // Bus has a pull-down; nobody driving reads low
  assign line_w = line_oe ? line_out : (drv_oe ? drv_out : 1'h0);

  csr_responder #(.BIT_CYCLES(BITC)) csr_responder_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .line_in(line_w), .line_out(line_out),
    .line_oe(line_oe), .stored_addr(stored_addr), .meas_start(meas_start),
    .meas_ready(meas_ready), .cond_neg(cond_neg), .cond_len(cond_len),
    .cond_text(cond_text), .temp_neg(temp_neg), .temp_len(temp_len), .temp_text(temp_text)
  );
  csr_logger_model #(.BIT_CYCLES(BITC)) csr_logger_model_i (
    .clk_sys(clk_sys), .line(line_w), .drv_oe(drv_oe), .drv_out(drv_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [47:0] pack(input string s);
    logic [47:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++) v[8*i +: 8] = s[i];
    return v;
  endfunction

  function automatic string rec(input string b);
    string s;
    int sum;
    s = {b, "  "};
    s[s.len() - 2] = csr_pkg::SENSOR_TYPE_CH;
    sum = 0;
    for (int i = 0; i < s.len() - 1; i++) sum += s[i];
    s[s.len() - 1] = byte'(sum % 64 + 32);
    return s;
  endfunction

  task automatic expect_str(input string s, input bit pwrup);
    logic [9:0] f;
    logic [7:0] c;
    for (int k = 0; k < s.len(); k++) begin
      c = s[k];
      csr_logger_model_i.get_char(pwrup, f);
      if (pwrup) `CHK("pwrup frame", {1'h1, c, 1'h0}, f)
      else `CHK("cmd frame", {1'h1, ^c[6:0], c[6:0], 1'h0}, f)
    end
  endtask

  task automatic cmd(input string c, input string r);
    csr_logger_model_i.send_cmd(c);
    if (r.len() > 0) expect_str(r, 1'b0);
  endtask

  task automatic wait_start();
    int n;
    n = 0;
    while (meas_start !== 1'h1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("meas_start", 1'h1, meas_start)
  endtask

  task automatic set_vals(input bit cn, input string c, input bit tn, input string t);
    @(negedge clk_sys);
    cond_neg = cn;
    cond_len = 3'(c.len());
    cond_text = pack(c);
    temp_neg = tn;
    temp_len = 3'(t.len());
    temp_text = pack(t);
    @(negedge clk_sys);
    meas_ready = 1'h1;
    @(negedge clk_sys);
    meas_ready = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    wait_start();
    repeat (2 * BITC) @(negedge clk_sys);
    `CHK("raised line", 1'h1, line_w)
    set_vals(1'h0, "5423", 1'h0, "22.3");
    expect_str(rec("\t5423 22.3\r"), 1'b1);
    repeat (BITC) @(negedge clk_sys);
    `CHK("released", 1'h0, line_oe)
    $display("test powerup done");
  endtask

  task automatic t_measure();
    cmd("0M!", "00012\r\n");
    wait_start();
    set_vals(1'h0, "5423", 1'h1, "1.5");
    expect_str("0\r\n", 1'b0);
    cmd("0D0!", "0+5423-1.5\r\n");
    $display("test measure done");
  endtask

  task automatic t_concurrent();
    cmd("?C!", "000102\r\n");
    wait_start();
    set_vals(1'h0, "77", 1'h1, "1.5");
    repeat (4 * BITC) @(negedge clk_sys);
    cmd("0D0!", "0+77-1.5\r\n");
    $display("test concurrent done");
  endtask

  task automatic t_continuous();
    cmd("0R0!", "");
    wait_start();
    set_vals(1'h1, "12", 1'h0, "3.0");
    expect_str("0-12+3.0\r\n", 1'b0);
    cmd("0R3!", "");
    wait_start();
    set_vals(1'h1, "8", 1'h1, "4.5");
    expect_str({"0", rec("\t-8 -4.5\r")}, 1'b0);
    $display("test continuous done");
  endtask

  task automatic t_suppress();
    logic seen;
    seen = 1'h0;
    @(negedge clk_sys);
    rst_n = 1'h0;
    stored_addr = 8'h35;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (4 * BITC) begin
      @(negedge clk_sys);
      seen = seen | line_oe | meas_start;
    end
    `CHK("quiet boot", 1'h0, seen)
    // A command for another address must leave the line and the sensor alone
    csr_logger_model_i.send_cmd("0M!");
    repeat (4 * BITC) begin
      @(negedge clk_sys);
      seen = seen | line_oe | meas_start;
    end
    `CHK("foreign address", 1'h0, seen)
    cmd("5M!", "50012\r\n");
    $display("test suppress done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'h1;
    t_powerup();
    t_measure();
    t_concurrent();
    t_continuous();
    t_suppress();
    complete_run();
  end

  // About three times the traffic the tests generate at this bit time
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
endmodule // tb

bind csr_responder csr_responder_chk #(
  .BIT_CYCLES(BIT_CYCLES), .VAL_CHARS(VAL_CHARS), .LW(LW)
) csr_responder_chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe), .stored_addr(stored_addr), .meas_start(meas_start),
  .meas_ready(meas_ready), .cond_neg(cond_neg), .cond_len(cond_len),
  .cond_text(cond_text), .temp_neg(temp_neg), .temp_len(temp_len), .temp_text(temp_text)
);

`undef CHK

`default_nettype wire
